// ### bench/usc_checker.sv
// checker for the strap status ports
`timescale 1ns/100ps
module usc_checker
  import usc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic chipEnableN,
  input wire logic pullupSensed,
  input wire logic disconnectSensed,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic dcOut,
  input wire logic dcOe,
  input wire logic i2cModeOut,
  input wire logic coreRegulatorOut,
  input wire logic [6:0] i2cTargetAddr,
  input wire logic [1:0] acGainOut,
  input wire logic [1:0] dcGainOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_ad; i2cTargetAddr == I2C_TARGET_ADDR; endproperty
  a_ad: assert property (p_ad) else $error("addr");
  property p_ce; !chipEnableN [*4] |-> !sclOe && !dcOe && !dcOut; endproperty
  a_ce: assert property (p_ce) else $error("enable");
  property p_im; i2cModeOut |-> !dcOe && dcGainOut == DC_GAIN_60MV; endproperty
  a_im: assert property (p_im) else $error("bus mode");
  property p_oe; (sclOe || dcOe) |-> !i2cModeOut; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_rg; dcOe |-> coreRegulatorOut == dcOut; endproperty
  a_rg: assert property (p_rg) else $error("regulator");
  property p_st; sclOe && $past(sclOe) |-> $stable(acGainOut) && $stable(dcGainOut); endproperty
  a_st: assert property (p_st) else $error("gain");
  property p_at; $rose(sclOut) |-> $past(pullupSensed); endproperty
  a_at: assert property (p_at) else $error("attach");
  property p_dc; disconnectSensed && sclOe |=> !sclOut && !dcOut; endproperty
  a_dc: assert property (p_dc) else $error("detach");
endmodule : usc_checker
bind usc_strap_status usc_checker usc_checker_i (.*);

// ### bench/usc_strap_status_tb.sv
// bench for the strap status logic
`timescale 1ns/100ps
module usc_strap_status_tb;
  import usc_pkg::*;
  logic clk_sys = 0, resetn = 0, chipEnableN = 0, sdaIn = 1, sclIn = 1, go = 0;
  logic acStrapFloat = 0, dcPinHigh = 0, dcPinFloat = 0, pullupSensed = 0;
  logic disconnectSensed = 0, fixtureSeen = 0, testPacketSeen = 0;
  logic busResetSeen, chirpJ, chirpK, squelch, sclOut, sclOe, dcOut, dcOe;
  logic i2cModeOut, coreRegulatorOut;
  logic [6:0] i2cTargetAddr;
  logic [1:0] acStrapLevel = 0, acGainOut, dcGainOut;
  int jLen = 0, kLen = 0, error_cnt = 0, num_checks = 0;
  usc_strap_status usc_strap_status_i (.*);
  usc_usb_peer usc_usb_peer_i (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task chk(input logic [6:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %0h not %0h", $time, got, exp);
    end
  endtask : chk
  task complete_run;
    $display("%0d checks, %0d wrong", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task boot(input logic bus);
    chipEnableN = 0;
    sdaIn = bus;
    tick(4);
    chipEnableN = 1;
    tick(6);
  endtask : boot
  task hs(input int j, k, input logic exp);
    jLen = j;
    kLen = k;
    go = 1;
    tick(1);
    go = 0;
    for (int i = 0; i < 30000 && dcOut !== 1'h1; i++) tick(1);
    chk(coreRegulatorOut, 7'(exp));
    chk(dcOut, 7'(exp));
    if (dcOut !== exp) complete_run();
    $display("high speed test done");
  endtask : hs
  initial begin
    tick(3);
    resetn = 1;
    boot(1);
    chk(i2cModeOut, 7'h1);
    chk(dcGainOut, 7'(DC_GAIN_60MV));
    chk(i2cTargetAddr, 7'h2C);
    chk(dcOe, 7'h0);
    $display("bus mode test done");
    for (int n = 0; n < 3; n++) begin
      acStrapFloat = n == 0;
      acStrapLevel = 2'(n);
      dcPinHigh = n == 0;
      dcPinFloat = n == 1;
      boot(0);
      acStrapLevel = ~acStrapLevel;
      tick(2);
      chk(acGainOut, n ? 7'(n) : 7'(AC_GAIN_MAX));
      chk(dcGainOut, 7'(2 - n));
      chk(sclOe, 7'h1);
    end
    $display("strap test done");
    pullupSensed = 1;
    tick(2);
    chk(sclOut, 7'h1);
    pullupSensed = 0;
    disconnectSensed = 1;
    tick(2);
    chk(sclOut, 7'h0);
    disconnectSensed = 0;
    $display("attach test done");
    hs(3000, 4000, 0);
    boot(0);
    hs(3700, 25500, 1);
    boot(0);
    hs(3600, 3600, 1);
    boot(0);
    fixtureSeen = 1;
    testPacketSeen = 1;
    tick(2);
    chk(dcOut, 7'h1);
    $display("fixture test done");
    boot(1);
    chk(dcGainOut, 7'(DC_GAIN_60MV));
    chk(dcOe, 7'h0);
    $display("bus mode retest done");
    complete_run();
  end
endmodule : usc_strap_status_tb

// ### bench/usc_usb_peer.sv
// usb far side: bus reset, chirp pair, squelch
`timescale 1ns/100ps
module usc_usb_peer (
  input wire logic clk_sys,
  input wire logic go,
  input var int jLen,
  input var int kLen,
  output logic busResetSeen = 0,
  output logic chirpJ = 0,
  output logic chirpK = 0,
  output logic squelch = 0
);
  always @(posedge go) begin
    @(posedge clk_sys) #1 busResetSeen = 1;
    @(posedge clk_sys) #1 busResetSeen = 0;
    chirpJ = 1;
    repeat (jLen) @(posedge clk_sys);
    #1 chirpJ = 0;
    chirpK = 1;
    repeat (kLen) @(posedge clk_sys);
    #1 chirpK = 0;
    repeat (3) @(posedge clk_sys);
    #1 squelch = 1;
    @(posedge clk_sys) #1 squelch = 0;
  end
endmodule : usc_usb_peer

// ### logic/usc_strap_status.sv
// strap sampling and attach / high-speed status flags
// Behaviour
// RULE1: chip enable low holds logic reset
// RULE2: both i2c pins high selects bus mode
// RULE3: bus mode answers as target 0x2C
// RULE4: clock pin outputs attach flag in strap
// RULE5: ac gain latched only at enable release
// RULE6: floating ac strap selects maximum boost
// RULE7: dc pin three level: 80/60/40 mV
// RULE8: dc pin outputs high-speed flag in strap
// RULE9: compliance fixture plus test packet sets flag
// RULE10: one chirp J/K pair 18-128 us
// RULE11: regulator enabled only in high speed
// RULE12: enable held low until supply good
// RULE13: bus mode leaves dc pin unused
`timescale 1ns/100ps
module usc_strap_status
  import usc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic chipEnableN,
  input wire logic sdaIn,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic acStrapFloat,
  input wire logic [1:0] acStrapLevel,
  input wire logic dcPinHigh,
  input wire logic dcPinFloat,
  output logic dcOut,
  output logic dcOe,
  input wire logic pullupSensed,
  input wire logic disconnectSensed,
  input wire logic busResetSeen,
  input wire logic chirpJ,
  input wire logic chirpK,
  input wire logic squelch,
  input wire logic fixtureSeen,
  input wire logic testPacketSeen,
  output logic i2cModeOut,
  output logic [6:0] i2cTargetAddr,
  output logic [1:0] acGainOut,
  output logic [1:0] dcGainOut,
  output logic coreRegulatorOut
);
  usc_regs_t q, d;
  logic rstAll;
  logic busModeStrap;
  logic [1:0] acGainStrap;
  logic [1:0] dcGainStrap;
  logic chirpLongEnough;
  logic chirpTooLong;
  logic fixtureEvent;
  logic handshakeAbort;
  logic strapMode;
  logic strapTaken;
  logic statusDrive;

  // enable pin low means reset; used only after its two flops
  assign rstAll = ~q.enSync[1]; // RULE1

  // bus mode needs both i2c lines high after sync
  assign busModeStrap = q.pinSync.sda & q.pinSync.scl; // RULE2

  // floating ac strap forces the strongest boost
  assign acGainStrap = q.pinSync.acFloat ? AC_GAIN_MAX : q.pinSync.acLevel; // RULE6

  // three level dc strap: high, floating, low
  assign dcGainStrap = q.pinSync.dcFloat ? DC_GAIN_60MV :
                       (q.pinSync.dcHigh ? DC_GAIN_80MV : DC_GAIN_40MV); // RULE7

  // count sits one below the chirp length on its last cycle
  assign chirpLongEnough = (q.chirpCnt >= CNT_W'(CHIRP_MIN_CYC - 1)); // RULE10
  assign chirpTooLong = (q.chirpCnt >= CNT_W'(CHIRP_MAX_CYC)); // RULE10

  // compliance fixture and test packet pattern seen in the same cycle
  assign fixtureEvent = fixtureSeen & testPacketSeen; // RULE9

  // any further chirp spoils the single pair
  assign handshakeAbort = chirpJ | chirpK;

  assign strapMode = ~q.i2cMode;
  assign strapTaken = (q.state != ST_STRAP);

  always_comb begin
    d = q;
    d.enSync = {q.enSync[0], chipEnableN};
    // every strap pin goes through two flops
    d.pinMeta = '{
      sda: sdaIn,
      scl: sclIn,
      acFloat: acStrapFloat,
      acLevel: acStrapLevel,
      dcHigh: dcPinHigh,
      dcFloat: dcPinFloat
    };
    d.pinSync = q.pinMeta;
    if (rstAll) begin
      d.state = ST_STRAP; // RULE1
      d.attached = 1'b0;
      d.hsActive = 1'b0;
      d.chirpCnt = '0;
    end else begin
      case (q.state)
        ST_STRAP: begin
          // first cycle after enable release samples every strap
          // later strap changes have no path into the gains
          d.i2cMode = busModeStrap; // RULE2
          d.acGain = acGainStrap; // RULE5 RULE6
          if (busModeStrap) begin
            d.dcGain = DC_GAIN_RESET; // RULE13
          end else begin
            d.dcGain = dcGainStrap; // RULE7
          end
          d.state = ST_IDLE;
        end
        ST_IDLE: begin
          if (pullupSensed) begin
            d.attached = 1'b1; // RULE4
          end
          if (fixtureEvent) begin
            d.state = ST_HS; // RULE9
          end else if (busResetSeen) begin
            d.state = ST_RESET;
          end
        end
        ST_RESET: begin
          // chirp j starts the handshake timer
          d.chirpCnt = '0;
          if (chirpJ) begin
            d.state = ST_CHIRP_J;
          end
        end
        ST_CHIRP_J: begin
          d.chirpCnt = q.chirpCnt + 1'b1;
          // j must hand over straight to k
          if (!chirpJ) begin
            d.chirpCnt = '0;
            if (chirpK && chirpLongEnough) begin
              d.state = ST_CHIRP_K; // RULE10
            end else begin
              d.state = ST_IDLE;
            end
          end else if (chirpTooLong) begin
            d.state = ST_IDLE; // RULE10
          end
        end
        ST_CHIRP_K: begin
          d.chirpCnt = q.chirpCnt + 1'b1;
          if (!chirpK) begin
            d.chirpCnt = '0;
            if (chirpLongEnough) begin
              d.state = ST_WAIT_SQ; // RULE10
            end else begin
              d.state = ST_IDLE;
            end
          end else if (chirpTooLong) begin
            d.state = ST_IDLE; // RULE10
          end
        end
        ST_WAIT_SQ: begin
          if (handshakeAbort) begin
            d.state = ST_IDLE; // second pair is not a single handshake
          end else if (squelch) begin
            d.state = ST_HS; // RULE10
          end
        end
        ST_HS: begin
          // a new bus reset repeats the handshake
          if (busResetSeen) begin
            d.state = ST_RESET;
          end
        end
        default: begin
          d.chirpCnt = '0;
          d.state = ST_IDLE;
        end
      endcase
      d.hsActive = (d.state == ST_HS); // RULE8
      // disconnect wins over every other event
      if (disconnectSensed) begin
        d.attached = 1'b0; // RULE4
        d.hsActive = 1'b0;
        d.state = ST_IDLE;
      end
    end
  end

  // one register stage holds all state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '{
        enSync: 2'h0,
        pinMeta: '0,
        pinSync: '0,
        i2cMode: 1'b0,
        acGain: AC_GAIN_RESET,
        dcGain: DC_GAIN_RESET,
        attached: 1'b0,
        hsActive: 1'b0,
        chirpCnt: '0,
        state: ST_STRAP
      };
    end else begin
      q <= d;
    end
  end

  // status pins driven only in strap mode after reset
  assign statusDrive = ~rstAll & strapMode & strapTaken;
  assign sclOut = q.attached; // RULE4
  assign sclOe = statusDrive; // RULE4
  assign dcOut = q.hsActive; // RULE8
  assign dcOe = statusDrive; // RULE8 RULE13
  assign i2cModeOut = q.i2cMode; // RULE3
  assign i2cTargetAddr = I2C_TARGET_ADDR; // RULE3
  assign acGainOut = q.acGain;
  assign dcGainOut = q.dcGain;
  // regulator follows the high speed flag, off in reset
  assign coreRegulatorOut = q.hsActive & ~rstAll; // RULE11
endmodule : usc_strap_status

// ### pkg/usc_pkg.sv
// constants and types for the usb conditioner strap and status logic
package usc_pkg;
  localparam int CLK_MHZ = 200;
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h2C;
  localparam int CHIRP_MIN_US = 18;
  localparam int CHIRP_MAX_US = 128;
  localparam int CHIRP_MIN_CYC = CHIRP_MIN_US * CLK_MHZ;
  localparam int CHIRP_MAX_CYC = CHIRP_MAX_US * CLK_MHZ;
  localparam int CNT_W = 16;
  // dc and ac gain codes
  localparam logic [1:0] DC_GAIN_40MV = 2'h0;
  localparam logic [1:0] DC_GAIN_60MV = 2'h1;
  localparam logic [1:0] DC_GAIN_80MV = 2'h2;
  localparam logic [1:0] AC_GAIN_MAX = 2'h3;
  localparam logic [1:0] AC_GAIN_RESET = 2'h0;
  localparam logic [1:0] DC_GAIN_RESET = 2'h1;

  typedef enum logic [2:0] {
    ST_STRAP,
    ST_IDLE,
    ST_RESET,
    ST_CHIRP_J,
    ST_CHIRP_K,
    ST_WAIT_SQ,
    ST_HS
  } usc_state_t;

  // strap pin levels, synced as one group
  typedef struct packed {
    logic sda;
    logic scl;
    logic acFloat;
    logic [1:0] acLevel;
    logic dcHigh;
    logic dcFloat;
  } usc_pins_t;

  typedef struct packed {
    logic [1:0] enSync;
    usc_pins_t pinMeta;
    usc_pins_t pinSync;
    logic i2cMode;
    logic [1:0] acGain;
    logic [1:0] dcGain;
    logic attached;
    logic hsActive;
    logic [CNT_W-1:0] chirpCnt;
    usc_state_t state;
  } usc_regs_t;
endpackage : usc_pkg
